/* src/switch_ctrl_pkg.sv */
// Purpose: Constants and types of the switch control
// Assumes: 16-bit numbered register words
// Notes:   All offsets, fields, resets and codes live here
package switch_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_VOLT_REF      = 8'h14;  // Matching voltage reference
    localparam logic [7:0] ADDR_MASK_LOW      = 8'h1b;  // alarm_trip_mask_low
    localparam logic [7:0] ADDR_MASK_HIGH     = 8'h1c;  // alarm_trip_mask_high
    localparam logic [7:0] ADDR_INPUT_CONFIG  = 8'h22;  // Contact-input routing
    localparam logic [7:0] ADDR_STATUS        = 8'h37;  // Status word
    localparam logic [7:0] ADDR_ALARM_LOW     = 8'h38;  // active_alarm_word_low
    localparam logic [7:0] ADDR_ALARM_HIGH    = 8'h39;  // active_alarm_word_high
    localparam logic [7:0] ADDR_COMMAND       = 8'h58;  // Command word

    // ------------------------------------------------------------------
    // Field layout and codes
    // ------------------------------------------------------------------
    localparam int         HIGH_ALARM_BITS    = 11;     // Alarms 17..27
    localparam int         ALARM24_BIT        = 7;      // Alarm 24 in high word
    localparam int         STAT_MATCH_BIT     = 12;     // Magnitude match flag
    localparam int         STAT_MODE_BIT      = 10;     // Matching mode flag
    localparam logic [15:0] CMD_MATCH_ON      = 16'h0002;
    localparam logic [15:0] CMD_MATCH_OFF     = 16'h0004;
    localparam logic [15:0] CFG_SERIAL_A      = 16'h0000; // Command route
    localparam logic [15:0] CFG_SERIAL_B      = 16'h0008; // Command route
    localparam logic [15:0] CFG_CONTACT_A     = 16'h0010; // Contact route
    localparam logic [15:0] CFG_CONTACT_B     = 16'h0018; // Contact route

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] MASK_LOW_RESET    = 16'hffff;
    localparam logic [15:0] MASK_HIGH_RESET   = 16'h07ff;
    localparam logic [15:0] CONFIG_RESET      = 16'h0000;
    localparam logic [15:0] VOLT_REF_RESET    = 16'h0000;
    localparam logic [15:0] NOMINAL_LINE      = 16'h1000; // Nominal line reading

    // Line window in percent of nominal
    localparam logic [7:0]  LINE_HIGH_PCT     = 8'd110;
    localparam logic [7:0]  LINE_LOW_PCT      = 8'd90;
    localparam logic [7:0]  PCT_SCALE         = 8'd100;

    // Synchronised pin count
    localparam int          PIN_COUNT         = 5;

    // Operating state of the regulator mode
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_MATCHING,
        MODE_DROOP
    } mode_type;

endpackage

/* src/mode_ctrl_if.sv */
// Purpose: Carries mode requests and mode state between top and mode machine
// Assumes: Single clock domain
// Notes:   All request signals are one-cycle pulses except levels noted
`timescale 1ns/1ps
interface mode_ctrl_if;
    logic enter_cmd;     // Command-route entry pulse
    logic exit_cmd;      // Command-route exit pulse
    logic contact_route; // Contact input steers the mode (level)
    logic contact;       // Synchronised matching contact (level)
    logic off_key;       // Synchronised off key (level)
    logic par_closed;    // Synchronised parallel-closed feedback (level)
    logic alarm24;       // No-matching alarm (level)
    logic matching;      // Matching mode active (level)
    logic droop;         // Droop and power-factor mode active (level)

    modport ctrl (output enter_cmd, exit_cmd, contact_route, contact, off_key,
                  output par_closed, alarm24, input matching, droop);
    modport fsm  (input enter_cmd, exit_cmd, contact_route, contact, off_key,
                  input par_closed, alarm24, output matching, droop);
endinterface

/* src/pin_sync.sv */
// Purpose: Two-stage synchroniser for the contact and key pins
// Assumes: Pins are slow levels from switchgear and panel
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync
    import switch_ctrl_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic [PIN_COUNT-1:0] pins,
    output logic      [PIN_COUNT-1:0] pins_sync
);
    logic [PIN_COUNT-1:0] stage_reg; // First stage, metastability catch

    // Two flip-flops per pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage_reg <= '0;
            pins_sync <= '0;
        end else begin
            stage_reg <= pins;
            pins_sync <= stage_reg;
        end
    end
endmodule

/* src/match_mode_fsm.sv */
// Purpose: Voltage-matching and droop mode sequencing
// Assumes: Requests arrive synchronised through the mode interface
// Notes:   Idle ignores exit causes; they act once matching has been entered
`timescale 1ns/1ps
module match_mode_fsm
    import switch_ctrl_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    mode_ctrl_if.fsm  mode
);
    mode_type state_reg;   // Present mode
    mode_type state_next;  // Next mode
    logic     contact_prev; // Contact level one cycle back

    // Contact edge tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            contact_prev <= 1'b0;
        end else begin
            contact_prev <= mode.contact;
        end
    end

    // Next mode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MODE_IDLE: begin
                if (mode.par_closed) begin
                    state_next = MODE_IDLE;
                end else if (mode.enter_cmd) begin
                    state_next = MODE_MATCHING;
                end else if (mode.contact_route && mode.contact && !contact_prev) begin
                    state_next = MODE_MATCHING;
                end
            end
            MODE_MATCHING: begin
                if (mode.par_closed) begin
                    state_next = MODE_DROOP;
                end else if (mode.alarm24) begin
                    state_next = MODE_IDLE;
                end else if (mode.exit_cmd || mode.off_key) begin
                    state_next = MODE_IDLE;
                end else if (mode.contact_route && !mode.contact) begin
                    state_next = MODE_IDLE;
                end
            end
            MODE_DROOP: begin
                // Droop holds while the parallel switch stays closed
                if (!mode.par_closed) begin
                    state_next = MODE_IDLE;
                end
            end
            default: begin
                state_next = MODE_IDLE;
            end
        endcase
    end

    // Mode register and decoded outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg     <= MODE_IDLE;
            mode.matching <= 1'b0;
            mode.droop    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            mode.matching <= (state_next == MODE_MATCHING);
            mode.droop    <= (state_next == MODE_DROOP);
        end
    end
endmodule

/* src/parallel_switch_alarm_mask_control.sv */
// Purpose: Alarm-mask trip of the enable contact,
//          matching mode control and register words
// Assumes: Registers, alarms and line reading on clk_sys;
//          contacts and keys are asynchronous pins
//
// Notes:   Enable contact output is high while closed
`timescale 1ns/1ps
module parallel_switch_alarm_mask_control
    import switch_ctrl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register word access
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // Alarm sources
    input  wire logic [15:0] alarm_in_low,
    input  wire logic [10:0] alarm_in_high,
    input  wire logic [15:0] line_level,
    // Contacts, keys and comparator pins
    input  wire logic        match_contact,
    input  wire logic        par_closed_contact,
    input  wire logic        match_off_key,
    input  wire logic        magnitude_match,
    input  wire logic        rotating_bridge_jumper_read_en,
    // Results
    output logic             switch_enable_connector,
    output logic             line_mode_ind,
    output logic             droop_en,
    output logic             power_factor_regulation_en,
    output logic      [15:0] volt_ref
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // True when a write hits the given register number
    function automatic logic write_hit(input logic wr, input logic [7:0] addr,
                                       input logic [7:0] target);
        write_hit = wr && (addr == target);
    endfunction

    // True when the configuration word routes matching to the command word
    function automatic logic cfg_is_serial(input logic [15:0] cfg);
        cfg_is_serial = (cfg == CFG_SERIAL_A) || (cfg == CFG_SERIAL_B);
    endfunction

    // True when the configuration word routes matching to the contact input
    function automatic logic cfg_is_contact(input logic [15:0] cfg);
        cfg_is_contact = (cfg == CFG_CONTACT_A) || (cfg == CFG_CONTACT_B);
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0]          mask_low_reg;     // Trip mask, alarms 1..16
    logic [15:0]          mask_high_reg;    // Trip mask, alarms 17..27
    logic [15:0]          config_reg;       // Contact-input routing word
    logic [15:0]          alarm_low_reg;    // Latched alarm word, low
    logic [15:0]          alarm_high_reg;   // Latched alarm word, high
    logic                 alarm24_reg;      // No-matching alarm
    logic                 out_of_range_reg; // Line outside window
    logic [PIN_COUNT-1:0] pins_sync;        // Synchronised pins
    logic                 enter_cmd_reg;    // Entry command pulse
    logic                 exit_cmd_reg;     // Exit command pulse
    logic                 trip;             // Masked alarm present
    logic [15:0]          status_word;      // Assembled status
    logic [15:0]          rdata_next;       // Read mux result
    logic [10:0]          alarm_high_next;  // High alarm bits with alarm 24

    // Synchronised pin names
    logic                 contact_s;        // Matching contact closed
    logic                 par_closed_s;     // Parallel switch closed
    logic                 off_key_s;        // Off key pressed
    logic                 match_s;          // Magnitudes equal
    logic                 jumper_read_s;    // Bridge jumper reading on

    // Line comparison products
    logic [23:0]          line_scaled;      // Line reading times 100
    logic [23:0]          high_limit;       // Nominal times 110
    logic [23:0]          low_limit;        // Nominal times 90

    mode_ctrl_if mode ();

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    pin_sync u_pin_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pins      ({rotating_bridge_jumper_read_en, magnitude_match,
                     match_off_key, par_closed_contact, match_contact}),
        .pins_sync (pins_sync)
    );

    assign contact_s     = pins_sync[0];
    assign par_closed_s  = pins_sync[1];
    assign off_key_s     = pins_sync[2];
    assign match_s       = pins_sync[3];
    assign jumper_read_s = pins_sync[4];

    // ------------------------------------------------------------------
    // Writable words
    // ------------------------------------------------------------------

    // Trip masks, upper high bits forced to zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask_low_reg  <= MASK_LOW_RESET;
            mask_high_reg <= MASK_HIGH_RESET;
        end else begin
            if (write_hit(reg_wr, reg_addr, ADDR_MASK_LOW)) begin
                mask_low_reg <= reg_wdata;
            end
            if (write_hit(reg_wr, reg_addr, ADDR_MASK_HIGH)) begin
                mask_high_reg <= {5'h00, reg_wdata[HIGH_ALARM_BITS-1:0]};
            end
        end
    end

    // Input routing configuration
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            config_reg <= CONFIG_RESET;
        end else if (write_hit(reg_wr, reg_addr, ADDR_INPUT_CONFIG)) begin
            config_reg <= reg_wdata;
        end
    end

    // Matching voltage reference, driven straight out
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            volt_ref <= VOLT_REF_RESET;
        end else if (write_hit(reg_wr, reg_addr, ADDR_VOLT_REF)) begin
            volt_ref <= reg_wdata;
        end
    end

    // Command word decoding into one-cycle pulses
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enter_cmd_reg <= 1'b0;
            exit_cmd_reg  <= 1'b0;
        end else begin
            // Entry honoured only on command routing with jumper reading off
            enter_cmd_reg <= write_hit(reg_wr, reg_addr, ADDR_COMMAND)
                             && (reg_wdata == CMD_MATCH_ON)
                             && cfg_is_serial(config_reg) && !jumper_read_s;
            // Exit accepted from any routing
            exit_cmd_reg  <= write_hit(reg_wr, reg_addr, ADDR_COMMAND)
                             && (reg_wdata == CMD_MATCH_OFF);
        end
    end

    // ------------------------------------------------------------------
    // Line window and no-matching alarm
    // ------------------------------------------------------------------
    assign line_scaled = {8'h00, line_level} * {16'h0000, PCT_SCALE};
    assign high_limit  = {8'h00, NOMINAL_LINE} * {16'h0000, LINE_HIGH_PCT};
    assign low_limit   = {8'h00, NOMINAL_LINE} * {16'h0000, LINE_LOW_PCT};

    // Window compare registered to keep the multiply off the alarm path
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_of_range_reg <= 1'b0;
        end else begin
            out_of_range_reg <= (line_scaled > high_limit) || (line_scaled < low_limit);
        end
    end

    // Held until window regained, paralleled, exit command
    // or off key; raising it wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alarm24_reg <= 1'b0;
        end else if (out_of_range_reg && mode.matching && !par_closed_s) begin
            alarm24_reg <= 1'b1;
        end else if (!out_of_range_reg || par_closed_s || exit_cmd_reg || off_key_s) begin
            alarm24_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Active alarm words
    // ------------------------------------------------------------------

    // Alarm 24 slot carries the block's own no-matching alarm
    always_comb begin
        alarm_high_next = alarm_in_high;
        alarm_high_next[ALARM24_BIT] = alarm_in_high[ALARM24_BIT] || alarm24_reg;
    end

    // Latched words, alarms 1..16 low and 17..27 high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alarm_low_reg  <= '0;
            alarm_high_reg <= '0;
        end else begin
            alarm_low_reg  <= alarm_in_low;
            alarm_high_reg <= {5'h00, alarm_high_next};
        end
    end

    // Any single masked alarm trips the contact
    assign trip = |({alarm_high_reg, alarm_low_reg} & {mask_high_reg, mask_low_reg});

    // ------------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------------
    assign mode.enter_cmd     = enter_cmd_reg;
    assign mode.exit_cmd      = exit_cmd_reg;
    assign mode.contact_route = cfg_is_contact(config_reg) && !jumper_read_s;
    assign mode.contact       = contact_s;
    assign mode.off_key       = off_key_s;
    assign mode.par_closed    = par_closed_s;
    assign mode.alarm24       = alarm_high_reg[ALARM24_BIT];

    match_mode_fsm u_match_mode_fsm (
        .clk_sys (clk_sys),
        .rst     (rst),
        .mode    (mode)
    );

    // ------------------------------------------------------------------
    // Contact and mode outputs
    // ------------------------------------------------------------------

    // Closes on match or once paralleled,
    // opens on any masked alarm or alarm 24
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            switch_enable_connector <= 1'b0;
        end else if (trip) begin
            switch_enable_connector <= 1'b0;
        end else if (alarm24_reg) begin
            switch_enable_connector <= 1'b0;
        end else begin
            switch_enable_connector <= match_s || par_closed_s;
        end
    end

    // Line indication and droop regulation follow the mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_mode_ind              <= 1'b0;
            droop_en                   <= 1'b0;
            power_factor_regulation_en <= 1'b0;
        end else begin
            line_mode_ind              <= mode.matching;
            droop_en                   <= mode.droop;
            power_factor_regulation_en <= mode.droop;
        end
    end

    // ------------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------------

    // Status word with match and mode flags
    always_comb begin
        status_word = '0;
        status_word[STAT_MATCH_BIT] = match_s;
        status_word[STAT_MODE_BIT]  = mode.matching;
    end

    // Read multiplexer; unmapped numbers read zero
    always_comb begin
        if (reg_addr == ADDR_MASK_LOW) begin
            rdata_next = mask_low_reg;
        end else if (reg_addr == ADDR_MASK_HIGH) begin
            rdata_next = mask_high_reg;
        end else if (reg_addr == ADDR_ALARM_LOW) begin
            rdata_next = alarm_low_reg;
        end else if (reg_addr == ADDR_ALARM_HIGH) begin
            rdata_next = alarm_high_reg;
        end else if (reg_addr == ADDR_STATUS) begin
            rdata_next = status_word;
        end else if (reg_addr == ADDR_INPUT_CONFIG) begin
            rdata_next = config_reg;
        end else if (reg_addr == ADDR_VOLT_REF) begin
            rdata_next = volt_ref;
        end else begin
            rdata_next = '0;
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

endmodule

/* test/switch_ctrl_monitor.sv */
// Purpose: Port checker of the switch control
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to the top module after the module body
`timescale 1ns/1ps
module switch_ctrl_monitor
    import switch_ctrl_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        match_off_key,
    input wire logic        par_closed_contact,
    input wire logic        line_mode_ind,
    input wire logic        droop_en,
    input wire logic        power_factor_regulation_en,
    input wire logic [15:0] volt_ref
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Feedback open or key held long enough to pass the synchroniser
    sequence s_par_open; !par_closed_contact [*6]; endsequence
    sequence s_key_held; match_off_key [*6]; endsequence
    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    property p_no_stray; !reg_rd |=> !reg_rvalid; endproperty
    property p_ref_write;
        reg_wr && reg_addr == ADDR_VOLT_REF |=> volt_ref == $past(reg_wdata);
    endproperty
    property p_cmd_zero;
        reg_rd && reg_addr == ADDR_COMMAND |=> reg_rdata == 16'h0000;
    endproperty
    property p_droop_pfr; droop_en == power_factor_regulation_en; endproperty
    property p_mode_excl; !(line_mode_ind && droop_en); endproperty
    property p_droop_from; $rose(droop_en) |-> $past(line_mode_ind); endproperty
    property p_droop_ends; s_par_open |-> !droop_en; endproperty
    property p_key_exit; s_key_held |-> !line_mode_ind; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("no read answer");
    a_no_stray: assert property (p_no_stray)
        else $error("stray read valid");
    a_ref_write: assert property (p_ref_write)
        else $error("reference not taken");
    a_cmd_zero: assert property (p_cmd_zero)
        else $error("command read not zero");
    a_droop_pfr: assert property (p_droop_pfr)
        else $error("droop and pf differ");
    a_mode_excl: assert property (p_mode_excl)
        else $error("matching with droop");
    a_droop_from: assert property (p_droop_from)
        else $error("droop without matching");
    a_droop_ends: assert property (p_droop_ends)
        else $error("droop with feedback open");
    a_key_exit: assert property (p_key_exit)
        else $error("matching with off key");
endmodule
bind parallel_switch_alarm_mask_control switch_ctrl_monitor i_switch_ctrl_monitor (.*);

/* test/switchgear_model.sv */
// Purpose: Switchgear closing the parallel breaker and its feedback contact
// Assumes: Breaker may close only while the enable contact is closed
// Notes:   Delay input makes the breaker prompt or slow
`timescale 1ns/1ps
module switchgear_model (
    input  wire logic       clk_sys,
    input  wire logic       close_req,      // Operator asks to parallel
    input  wire logic       enable_contact, // Enable contact of the regulator
    input  wire logic [3:0] delay,          // Cycles before the breaker closes
    output logic            fb_contact      // Parallel-closed feedback
);
    int cnt = 0;
    initial fb_contact = 1'b0;
    // Feedback closes together with the breaker, opens when released
    always @(posedge clk_sys) begin
        cnt <= (close_req && enable_contact) ? cnt + 1 : 0;
        fb_contact <= close_req && (fb_contact || (enable_contact && cnt >= delay));
    end
endmodule

/* test/parallel_switch_alarm_mask_control_tb.sv */
// Purpose: Self-checking bench of the switch control
// Assumes: Register words and pins driven at the rising edge
// Notes:   Expected values are computed inline next to each check
`timescale 1ns/1ps
module parallel_switch_alarm_mask_control_tb;
    import switch_ctrl_pkg::*;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid;
    logic match_contact = 0, par_closed_contact, match_off_key = 0, close_req = 0;
    logic magnitude_match = 0, jumper = 0, switch_enable_connector, line_mode_ind;
    logic droop_en, power_factor_regulation_en;
    logic [7:0] reg_addr = 0;
    logic [3:0] delay = 0;
    logic [10:0] alarm_in_high = 0;
    logic [15:0] reg_wdata = 0, alarm_in_low = 0, line_level = NOMINAL_LINE;
    logic [15:0] reg_rdata, volt_ref;
    int err_count = 0, samples_checked = 0, cyc = 0, mlo, mhi, al, ah;
    bit ser, con;
    always #20 clk_sys = ~clk_sys;
    parallel_switch_alarm_mask_control i_parallel_switch_alarm_mask_control (.*,
        .rotating_bridge_jumper_read_en(jumper));
    switchgear_model i_switchgear_model (.clk_sys(clk_sys), .close_req(close_req),
        .enable_contact(switch_enable_connector), .delay(delay),
        .fb_contact(par_closed_contact));
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk({reg_rvalid, reg_rdata}, {1'b1, exp});
    endtask
    // Timeout guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        cyc = $urandom(98);
        cyc = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(ADDR_MASK_LOW, MASK_LOW_RESET);
        rdc(ADDR_COMMAND, 16'h0000);
        rdc(8'h00, 16'h0000);
        wr(ADDR_VOLT_REF, 16'h0123);
        rdc(ADDR_VOLT_REF, 16'h0123);
        wr(ADDR_ALARM_LOW, 16'hffff);
        rdc(ADDR_ALARM_LOW, 16'h0000);
        magnitude_match <= 1'b1;
        // Random masks against one low alarm or many, with random high alarms except alarm 24
        for (int i = 0; i < 8; i++) begin
            mlo = $urandom & 16'hffff;
            mhi = $urandom & 16'hffff;
            al = (i < 4) ? (1 << $urandom_range(15)) : ($urandom & 16'hffff);
            ah = $urandom & 11'h77f;
            wr(ADDR_MASK_LOW, mlo[15:0]);
            wr(ADDR_MASK_HIGH, mhi[15:0]);
            rdc(ADDR_MASK_HIGH, {5'h0, mhi[10:0]});
            @(posedge clk_sys);
            alarm_in_low <= al[15:0];
            alarm_in_high <= ah[10:0];
            wt(6);
            chk(switch_enable_connector, ((al & mlo) | (ah & mhi)) == 0);
            rdc(ADDR_ALARM_HIGH, ah[15:0]);
        end
        alarm_in_low <= '0;
        alarm_in_high <= '0;
        wr(ADDR_MASK_LOW, 16'h0000);
        wr(ADDR_MASK_HIGH, 16'h0000);
        // Every input route with and without the jumper reading
        for (int k = 0; k < 8; k++) begin
            ser = k[1:0] < 2 && !k[2];
            con = k[1:0] >= 2 && !k[2];
            jumper <= k[2];
            wr(ADDR_INPUT_CONFIG, {11'h0, k[1:0], 3'h0});
            wr(ADDR_COMMAND, CMD_MATCH_ON);
            wt(6);
            chk(line_mode_ind, ser);
            wr(ADDR_COMMAND, CMD_MATCH_OFF);
            match_contact <= 1'b1;
            wt(6);
            chk(line_mode_ind, con);
            rdc(ADDR_STATUS, {3'h0, 1'b1, 1'b0, con, 10'h0});
            match_contact <= 1'b0;
            wt(6);
            chk(line_mode_ind, 1'b0);
        end
        jumper <= 1'b0;
        wr(ADDR_INPUT_CONFIG, CFG_SERIAL_A);
        wr(ADDR_COMMAND, CMD_MATCH_ON);
        match_off_key <= 1'b1;
        wt(8);
        chk(line_mode_ind, 1'b0);
        match_off_key <= 1'b0;
        wr(ADDR_COMMAND, CMD_MATCH_ON);
        delay <= 4'($urandom_range(7));
        close_req <= 1'b1;
        wt(20);
        chk({droop_en, power_factor_regulation_en, line_mode_ind}, 3'b110);
        close_req <= 1'b0;
        wt(8);
        chk(droop_en, 1'b0);
        // Line out of window high then low
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_COMMAND, CMD_MATCH_ON);
            wt(6);
            line_level <= j ? 16'h0e00 : 16'h1200;
            wt(8);
            chk({line_mode_ind, switch_enable_connector}, 2'b00);
            rdc(ADDR_ALARM_HIGH, 16'h0080);
            line_level <= NOMINAL_LINE;
            wt(8);
        end
        print_verdict();
    end
endmodule
